/* logic/csw_defines.vh */
// constants for the control/status word block: offsets, fields, modes
// assumes byte-wide access to the process image, most-significant byte first
//
// How it works
// - after reset both words are absent; configuration alone makes them appear
// - status word at input bytes 0x000-0x001, control word at output 0x200-0x201
// - words held most-significant byte first; lower address carries the high byte
// - enabled with start-up lock: no sub-network exchange until control data-valid set
// - disabled or no-lock: exchange starts as soon as fieldbus is online
// - status data-valid set means both directions exchange valid data
// - gateway never clears status data-valid on its own while online
// - status bit 13 set once every transaction completed successfully once
// - status bits 12..8 hold last report code, low byte its data
`ifndef CSW_DEFINES_VH
`define CSW_DEFINES_VH

// ==========================================
// process image offsets
`define CSW_ADDR_W        10
`define CSW_STAT_HI_ADDR  10'h000
`define CSW_STAT_LO_ADDR  10'h001
`define CSW_CTRL_HI_ADDR  10'h200
`define CSW_CTRL_LO_ADDR  10'h201

// ==========================================
// word fields
`define CSW_STAT_DV_BIT   13
`define CSW_CTRL_DV_BIT   13
`define CSW_CODE_W        5
`define CSW_WORD_RESET    16'h0000
`define CSW_CODE_RESET    5'h1f

// ==========================================
// configuration modes
`define CSW_MODE_OFF      2'h0
`define CSW_MODE_LOCK     2'h1
`define CSW_MODE_NOLOCK   2'h2

`endif

/* logic/csw_status_word.v */
// status word register: data-valid flag, last report code and data
// assumes report strobes and completion level synchronous to mclk
`timescale 1ns/1ps
`default_nettype none
`include "csw_defines.vh"

module csw_status_word (
  // clock and reset
  input  wire        mclk,
  input  wire        rst_n,
  // gateway state
  input  wire        online,
  input  wire        exch_en,
  input  wire        all_txn_done,
  // status report
  input  wire        rpt_valid,
  input  wire [4:0]  rpt_code,
  input  wire [7:0]  rpt_data,
  // word out
  output reg  [15:0] status_word_r
);

  reg  [15:0] status_word_nxt;

  always @* begin
    status_word_nxt = status_word_r;
    if (rpt_valid) begin
      status_word_nxt[12:8] = rpt_code;
      status_word_nxt[7:0]  = rpt_data;
    end
    if (!online) begin
      status_word_nxt[`CSW_STAT_DV_BIT] = 1'b0;
    end else if (exch_en && all_txn_done) begin
      status_word_nxt[`CSW_STAT_DV_BIT] = 1'b1;
    end
    // no other path clears the flag while online
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      // bits 15..13 start clear, code starts at no-error
      status_word_r <= {3'h0, `CSW_CODE_RESET, 8'h00};
    end else begin
      status_word_r <= status_word_nxt;
    end
  end

endmodule // csw_status_word
`default_nettype wire

/* logic/csw_ctrl_status.v */
// control/status word block: process image decode, control word, start-up lock
// assumes one byte access per cycle from the fieldbus side, synchronous to mclk
`timescale 1ns/1ps
`default_nettype none
`include "csw_defines.vh"

module csw_ctrl_status (
  // clock and reset
  input  wire        mclk,
  input  wire        rstn,
  // configuration
  input  wire [1:0]  cfg_mode,
  // fieldbus link and process image access
  input  wire        fb_online,
  input  wire        fb_wr,
  input  wire        fb_rd,
  input  wire [9:0]  fb_addr,
  input  wire [7:0]  fb_wdata,
  output reg  [7:0]  fb_rdata_r,
  output reg         fb_hit_r,
  // sub-network side
  input  wire        all_txn_done,
  input  wire        rpt_valid,
  input  wire [4:0]  rpt_code,
  input  wire [7:0]  rpt_data,
  output reg         exch_en_r,
  output reg         words_present_r,
  output reg  [15:0] ctrl_word_r,
  output wire [15:0] status_word
);

  // ==========================================
  // reset release
  reg        rst_s1_r;
  reg        rst_s2_r;
  wire       rst_n;

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  assign rst_n = rst_s2_r;

  // ==========================================
  // decode helpers
  function is_addr;
    input [9:0] a;
    input [9:0] b;
    begin
      is_addr = (a == b);
    end
  endfunction

  // ==========================================
  // configuration and states
  localparam [2:0] ST_OFFLINE = 3'b001;
  localparam [2:0] ST_LOCKED  = 3'b010;
  localparam [2:0] ST_EXCH    = 3'b100;

  reg  [1:0] mode_r;
  reg  [2:0] state_r;
  reg  [2:0] state_nxt;
  wire       present;
  wire       locked_mode;

  assign present     = (mode_r == `CSW_MODE_LOCK) || (mode_r == `CSW_MODE_NOLOCK);
  assign locked_mode = (mode_r == `CSW_MODE_LOCK);

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_OFFLINE: begin
        if (fb_online) begin
          state_nxt = locked_mode ? ST_LOCKED : ST_EXCH;
        end
      end
      ST_LOCKED: begin
        if (!fb_online) begin
          state_nxt = ST_OFFLINE;
        end else if (!locked_mode || ctrl_word_r[`CSW_CTRL_DV_BIT]) begin
          state_nxt = ST_EXCH;
        end
      end
      ST_EXCH: begin
        if (!fb_online) begin
          state_nxt = ST_OFFLINE;
        end
      end
      default: begin
        state_nxt = ST_OFFLINE;
      end
    endcase
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r          <= `CSW_MODE_OFF;
      state_r         <= ST_OFFLINE;
      exch_en_r       <= 1'b0;
      words_present_r <= 1'b0;
    end else begin
      mode_r          <= cfg_mode;
      state_r         <= state_nxt;
      exch_en_r       <= (state_nxt == ST_EXCH);
      words_present_r <= present;
    end
  end

  // ==========================================
  // control word and read path
  wire       hit_stat_hi;
  wire       hit_stat_lo;
  wire       hit_ctrl_hi;
  wire       hit_ctrl_lo;
  reg  [15:0] ctrl_word_nxt;
  reg  [7:0]  rdata_nxt;
  reg         hit_nxt;

  assign hit_stat_hi = present && is_addr(fb_addr, `CSW_STAT_HI_ADDR);
  assign hit_stat_lo = present && is_addr(fb_addr, `CSW_STAT_LO_ADDR);
  assign hit_ctrl_hi = present && is_addr(fb_addr, `CSW_CTRL_HI_ADDR);
  assign hit_ctrl_lo = present && is_addr(fb_addr, `CSW_CTRL_LO_ADDR);

  always @* begin
    ctrl_word_nxt = ctrl_word_r;
    rdata_nxt     = 8'h00;
    hit_nxt       = 1'b0;
    if (fb_wr && hit_ctrl_hi) begin
      ctrl_word_nxt[15:8] = fb_wdata;
    end
    if (fb_wr && hit_ctrl_lo) begin
      ctrl_word_nxt[7:0] = fb_wdata;
    end
    // status word is read only; writes there fall away
    if (fb_rd || fb_wr) begin
      hit_nxt = hit_stat_hi || hit_stat_lo || hit_ctrl_hi || hit_ctrl_lo;
    end
    if (fb_rd) begin
      if (hit_stat_hi) begin
        rdata_nxt = status_word[15:8];
      end else if (hit_stat_lo) begin
        rdata_nxt = status_word[7:0];
      end else if (hit_ctrl_hi) begin
        rdata_nxt = ctrl_word_r[15:8];
      end else if (hit_ctrl_lo) begin
        rdata_nxt = ctrl_word_r[7:0];
      end
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_word_r <= `CSW_WORD_RESET;
      fb_rdata_r  <= 8'h00;
      fb_hit_r    <= 1'b0;
    end else begin
      ctrl_word_r <= ctrl_word_nxt;
      fb_rdata_r  <= rdata_nxt;
      fb_hit_r    <= hit_nxt;
    end
  end

  // ==========================================
  // status word
  // data-valid flag marks full exchange
  csw_status_word u_status (
    .mclk          (mclk),
    .rst_n         (rst_n),
    .online        (fb_online),
    .exch_en       (exch_en_r),
    .all_txn_done  (all_txn_done),
    .rpt_valid     (rpt_valid),
    .rpt_code      (rpt_code),
    .rpt_data      (rpt_data),
    .status_word_r (status_word)
  );

endmodule // csw_ctrl_status
`default_nettype wire

/* tb/csw_ctrl_status_asserts.sv */
// checker: timing relations at the control/status word block ports
// assumes cfg_mode is held steady around every access
`timescale 1ns/1ps
`default_nettype none
module csw_ctrl_status_asserts (
  input wire logic        mclk, rstn, fb_online, fb_wr, fb_rd, all_txn_done, rpt_valid,
  input wire logic        exch_en_r, words_present_r, fb_hit_r,
  input wire logic [1:0]  cfg_mode,
  input wire logic [9:0]  fb_addr,
  input wire logic [7:0]  fb_wdata, fb_rdata_r, rpt_data,
  input wire logic [4:0]  rpt_code,
  input wire logic [15:0] ctrl_word_r, status_word
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // mode code 3 counts as off
  wire en = cfg_mode == 2'h1 || cfg_mode == 2'h2;
  // ==========================================
  // process image
  a_ctrl_write: assert property (fb_wr && !fb_rd && $past(en) && fb_addr == 10'h200
    |=> ctrl_word_r[15:8] == $past(fb_wdata)) else $error("control high byte not written");
  a_stat_read: assert property (fb_rd && $past(en) && fb_addr == 10'h001
    |=> fb_rdata_r == $past(status_word[7:0])) else $error("status low byte misplaced");
  a_off_refuse: assert property ((fb_rd || fb_wr) && !$past(en)
    |=> !fb_hit_r && fb_rdata_r == 8'h00) else $error("access answered while words absent");
  // ==========================================
  // exchange, data-valid and report
  a_lock_hold: assert property ($rose(exch_en_r) && $past(cfg_mode) == 2'h1
    |-> $past(ctrl_word_r[13])) else $error("exchange began without control data-valid");
  a_nolock_go: assert property (fb_online && !$past(fb_online) && $past(cfg_mode) != 2'h1
    |=> exch_en_r) else $error("exchange late after online");
  a_offline_clear: assert property (!fb_online
    |=> !exch_en_r && !status_word[13]) else $error("offline left exchange or data-valid");
  a_dv_hold: assert property ($past(fb_online) && $past(status_word[13])
    |-> status_word[13]) else $error("data-valid dropped while online");
  a_dv_set: assert property (exch_en_r && all_txn_done && fb_online
    |=> status_word[13]) else $error("data-valid not set");
  a_report: assert property (rpt_valid
    |=> status_word[12:0] == {$past(rpt_code), $past(rpt_data)}) else $error("report not loaded");
endmodule // csw_ctrl_status_asserts
bind csw_ctrl_status csw_ctrl_status_asserts csw_ctrl_status_asserts_i (.mclk, .rstn, .fb_online,
  .fb_wr, .fb_rd, .all_txn_done, .rpt_valid, .exch_en_r, .words_present_r, .fb_hit_r, .cfg_mode,
  .fb_addr, .fb_wdata, .fb_rdata_r, .rpt_data, .rpt_code, .ctrl_word_r, .status_word);
`default_nettype wire

/* tb/csw_host_model.sv */
// control system model: start-up handshake over the control word
// assumes bench routes its write strobe to the block while on is high
`timescale 1ns/1ps
`default_nettype none
module csw_host_model (
  input wire logic        mclk, on, fb_online,
  input wire logic [15:0] status_word,
  output logic            h_wr,
  output logic [9:0]      h_addr,
  output logic [7:0]      h_wdata
);
  // 0 offline, 1 online idle, 2 valid set, 3 exchanging
  logic [1:0] st = 0;
  initial {h_wr, h_addr, h_wdata} = 0;
  always @(posedge mclk) begin
    h_wr <= 1'b0;
    if (!fb_online || !on) begin
      if (st != 0) begin
        h_wr <= 1'b1;
        h_addr <= 10'h200;
        h_wdata <= 8'h00;
      end
      st <= 0;
    end else if (st == 0) st <= 1;
    else if (st == 1 && !status_word[13]) begin
      h_wr <= 1'b1;
      h_addr <= 10'h200;
      h_wdata <= 8'h20;
      st <= 2;
    end
    else if (st == 2 && status_word[13]) st <= 3;
  end
endmodule // csw_host_model
`default_nettype wire

/* tb/csw_ctrl_status_bench.sv */
// bench: scenarios for the control/status word block
// assumes host model owns the write port while host_on is high
`timescale 1ns/1ps
`default_nettype none
module csw_ctrl_status_bench;
  logic mclk = 0, rstn = 0, fb_online = 0, b_wr = 0, b_rd = 0, host_on = 0;
  logic all_txn_done = 0, rpt_valid = 0, h_wr, fb_hit_r, exch_en_r, words_present_r;
  logic [1:0] cfg_mode = 0;
  logic [9:0] b_addr = 0, h_addr;
  logic [7:0] b_wdata = 0, h_wdata, fb_rdata_r, rpt_data = 0;
  logic [4:0] rpt_code = 0;
  logic [15:0] ctrl_word_r, status_word;
  int fails = 0, check_count = 0;
  wire fb_wr = host_on ? h_wr : b_wr;
  wire [9:0] fb_addr = host_on ? h_addr : b_addr;
  wire [7:0] fb_wdata = host_on ? h_wdata : b_wdata;
  always #25 mclk = ~mclk;
  csw_ctrl_status csw_ctrl_status_i (.mclk, .rstn, .cfg_mode, .fb_online, .fb_wr, .fb_rd(b_rd),
    .fb_addr, .fb_wdata, .fb_rdata_r, .fb_hit_r, .all_txn_done, .rpt_valid, .rpt_code, .rpt_data,
    .exch_en_r, .words_present_r, .ctrl_word_r, .status_word);
  csw_host_model csw_host_model_i (.mclk, .on(host_on), .fb_online, .status_word, .h_wr, .h_addr,
    .h_wdata);
  // ==========================================
  // shared tasks
  task automatic chk(input string n, input logic [15:0] e, g);
    check_count++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", n, e, g);
      fails++;
    end
  endtask
  task automatic results;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge mclk);
    b_wr <= w;
    b_rd <= !w;
    b_addr <= a;
    b_wdata <= d;
    @(posedge mclk);
    b_wr <= 0;
    b_rd <= 0;
    #1;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // k 0 waits exchange, k 1 waits status data-valid
  task automatic wt(input logic k);
    for (int i = 0; i < 30 && (k ? status_word[13] : exch_en_r) !== 1'b1; i++) step(1);
    if ((k ? status_word[13] : exch_en_r) !== 1'b1) begin
      fails++;
      results;
    end
  endtask
  // ==========================================
  // scenarios
  task automatic t_off;
    acc(1, 10'h200, 8'h20);
    chk("off_hit", 0, fb_hit_r);
    acc(0, 10'h200, 0);
    chk("off_rdata", 0, fb_rdata_r);
    @(posedge mclk) fb_online <= 1;
    step(2);
    chk("exch_free", 1, exch_en_r);
    @(posedge mclk) fb_online <= 0;
    step(2);
    chk("exch_drop", 0, exch_en_r);
    $display("t_off done");
  endtask
  task automatic t_regs;
    @(posedge mclk) cfg_mode <= 2'h2;
    step(2);
    chk("present_on", 1, words_present_r);
    acc(1, 10'h200, 8'h12);
    chk("ctrl_hit", 1, fb_hit_r);
    acc(1, 10'h201, 8'h34);
    chk("ctrl", 16'h1234, ctrl_word_r);
    acc(0, 10'h200, 0);
    chk("ctrl_hi", 8'h12, fb_rdata_r);
    @(posedge mclk) {rpt_valid, rpt_code, rpt_data} <= {1'b1, 5'h04, 8'h5a};
    @(posedge mclk) rpt_valid <= 0;
    acc(0, 10'h000, 0);
    chk("stat_hi", 8'h04, fb_rdata_r);
    acc(1, 10'h001, 8'hff);
    chk("stat_wr_hit", 1, fb_hit_r);
    acc(0, 10'h001, 0);
    chk("stat_ro", 8'h5a, fb_rdata_r);
    acc(0, 10'h202, 0);
    chk("miss", 0, fb_hit_r);
    $display("t_regs done");
  endtask
  task automatic t_lock;
    @(posedge mclk) cfg_mode <= 2'h1;
    acc(1, 10'h200, 8'h00);
    @(posedge mclk) fb_online <= 1;
    step(6);
    chk("locked", 0, exch_en_r);
    @(posedge mclk) host_on <= 1;
    wt(0);
    @(posedge mclk) all_txn_done <= 1;
    wt(1);
    @(posedge mclk) all_txn_done <= 0;
    step(4);
    chk("dv_hold", 1, status_word[13]);
    @(posedge mclk) fb_online <= 0;
    step(3);
    chk("dv_clear", 0, status_word[13]);
    chk("host_clear", 0, ctrl_word_r[13]);
    @(posedge mclk) host_on <= 0;
    $display("t_lock done");
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    rstn <= 1;
    step(4);
    chk("stat_rst", 16'h1f00, status_word);
    chk("present", 0, words_present_r);
    t_off;
    t_regs;
    t_lock;
    results;
  end
endmodule // csw_ctrl_status_bench
`default_nettype wire
